// ---- dxs_strobes.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Row strobe low while the DRAM row address is driven.
// - 8-bit DRAM access uses the lower column strobe as the column strobe.
// - 16-bit DRAM upper byte access asserts upper column strobe on column (lower column strobe in a 2-WE system).
// - 16-bit DRAM lower byte access asserts lower column strobe on column.
// - DRAM parity selected: parity pins follow their byte lanes, others float.
// - Area 2 parity selected: parity pins used for area 2 external accesses.
// - External access drives low only the accessed area's chip select.
// - External access holds all other chip selects high.
// - Upper write strobe or lower lane select unused in 8-bit space.
module dxs_strobes (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire dxs_pkg::dxs_req_t req,
  input wire logic [1:0] parity_enable_field,
  output dxs_pkg::dxs_pins_t pins
);

  typedef struct packed {
    dxs_pkg::dxs_pins_t pins;
  } dxs_state_t;

  localparam dxs_state_t DXS_RST = '{pins: '{
    row_strobe_n: 1'b1,
    upper_col_strobe_n: 1'b1,
    lower_col_strobe_n: 1'b1,
    area_selects_n: dxs_pkg::DXS_SEL_IDLE,
    rd_n: 1'b1,
    upper_write_strobe_n: 1'b1,
    lower_write_strobe_n: 1'b1,
    upper_lane_select_n: 1'b1,
    lower_lane_select_n: 1'b1,
    addr_hold_out_n: 1'b0,
    addr: dxs_pkg::DXS_ADDR_RST,
    data_o: 16'h0000,
    data_oe: 2'h0,
    upper_parity_pin_o: 1'b0,
    lower_parity_pin_o: 1'b0,
    parity_oe: 2'h0}};

  dxs_state_t state_r;
  dxs_state_t state_nxt;
  logic [1:0] lane_on;
  logic [1:0] par_on;
  logic [1:0] par_bits;

  dxs_lanes u_lanes (
    .req(req),
    .parity_enable_field(parity_enable_field),
    .lane_on(lane_on),
    .par_on(par_on),
    .par_bits(par_bits)
  );

  // One-hot chip select, active low
  function automatic logic [7:0] dxs_sel_n(input logic [2:0] area);
    dxs_sel_n = ~(8'h01 << area);
  endfunction : dxs_sel_n

  // Next pin state from the current request
  always_comb begin
    state_nxt = DXS_RST; // Idle: all strobes high
    state_nxt.pins.addr = req.addr;
    unique case (req.space)
      dxs_pkg::DXS_SP_DRAM: begin
        state_nxt.pins.row_strobe_n = 1'b0;
        state_nxt.pins.rd_n = req.write;
        if (req.col_phase) begin
          if (!req.wide) begin
            state_nxt.pins.lower_col_strobe_n = 1'b0;
          end else if (req.two_we) begin
            state_nxt.pins.lower_col_strobe_n = 1'b0;
          end else begin
            state_nxt.pins.upper_col_strobe_n = ~req.upper;
            state_nxt.pins.lower_col_strobe_n = ~req.lower;
          end
        end
        // Area 1 select low except where it carries the upper column strobe
        if (!req.wide || req.two_we) begin
          state_nxt.pins.area_selects_n[1] = 1'b0;
        end else begin
          state_nxt.pins.area_selects_n[1] =
            state_nxt.pins.upper_col_strobe_n;
        end
        if (req.write) begin
          if (req.wide && req.two_we) begin
            state_nxt.pins.upper_write_strobe_n = ~req.upper;
            state_nxt.pins.lower_write_strobe_n = ~req.lower;
          end else begin
            state_nxt.pins.lower_write_strobe_n = 1'b0;
          end
        end
      end
      dxs_pkg::DXS_SP_EXT: begin
        state_nxt.pins.area_selects_n = dxs_sel_n(req.area);
        state_nxt.pins.rd_n = req.write;
        if (!req.wide) begin
          // Only the common write strobe in 8-bit space
          state_nxt.pins.lower_write_strobe_n = ~req.write;
        end else if (req.two_we) begin
          state_nxt.pins.lower_write_strobe_n = ~req.write;
          state_nxt.pins.upper_lane_select_n = ~req.upper;
          state_nxt.pins.lower_lane_select_n = ~req.lower;
          state_nxt.pins.addr[0] = ~req.upper; // Pin carries lane select
        end else if (req.write) begin
          state_nxt.pins.upper_write_strobe_n = ~req.upper;
          state_nxt.pins.lower_write_strobe_n = ~req.lower;
        end
      end
      default: begin
      end
    endcase
    // Data lanes and parity pins
    if (req.space != dxs_pkg::DXS_SP_IDLE) begin
      state_nxt.pins.data_o = req.wdata;
      state_nxt.pins.data_oe = req.write ? lane_on : 2'h0;
      state_nxt.pins.upper_parity_pin_o = par_bits[1];
      state_nxt.pins.lower_parity_pin_o = par_bits[0];
      state_nxt.pins.parity_oe = req.write ? par_on : 2'h0;
    end
  end

  // Registered pins, frozen while clk_en is low
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= DXS_RST;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  assign pins = state_r.pins;

endmodule : dxs_strobes

// ---- dxs_pkg.sv ----
package dxs_pkg;

  // Address space being accessed
  typedef enum logic [2:0] {
    DXS_SP_IDLE = 3'b001,
    DXS_SP_DRAM = 3'b010,
    DXS_SP_EXT = 3'b100
  } dxs_space_t;

  // Parity enable field encodings, and the area number checked under DXS_PAR_AREA2
  localparam logic [1:0] DXS_PAR_OFF = 2'h0;
  localparam logic [1:0] DXS_PAR_DRAM = 2'h1;
  localparam logic [1:0] DXS_PAR_AREA2 = 2'h2;
  localparam logic [2:0] DXS_PAR_AREA = 3'h2;

  // Reset values
  localparam logic [7:0] DXS_SEL_IDLE = 8'h00ff;
  localparam logic [21:0] DXS_ADDR_RST = 22'h00_0000;

  // Access request from the bus state controller
  typedef struct packed {
    dxs_space_t space;
    logic wide;       // 16-bit space
    logic upper;      // Upper byte touched
    logic lower;      // Lower byte touched
    logic write;
    logic two_we;     // DRAM 2-WE system, or ext WR/UPPER_LANE_SELECT/LOWER_LANE_SELECT system
    logic [2:0] area;
    logic col_phase;  // DRAM column phase
    logic [21:0] addr;
    logic [15:0] wdata;
  } dxs_req_t;

  // Pin outputs
  typedef struct packed {
    logic row_strobe_n;
    logic upper_col_strobe_n;
    logic lower_col_strobe_n;
    logic [7:0] area_selects_n;
    logic rd_n;
    logic upper_write_strobe_n;
    logic lower_write_strobe_n;
    logic upper_lane_select_n;
    logic lower_lane_select_n;
    logic addr_hold_out_n;
    logic [21:0] addr;
    logic [15:0] data_o;
    logic [1:0] data_oe;
    logic upper_parity_pin_o;
    logic lower_parity_pin_o;
    logic [1:0] parity_oe;
  } dxs_pins_t;

endpackage : dxs_pkg

// ---- dxs_lanes.sv ----
`timescale 1ns/1ps
// Works out lane usage and parity pins for one access
module dxs_lanes (
  input wire dxs_pkg::dxs_req_t req,
  input wire logic [1:0] parity_enable_field,
  output logic [1:0] lane_on,
  output logic [1:0] par_on,
  output logic [1:0] par_bits
);
  logic par_sel;

  // 8-bit space uses only the lower lane
  assign lane_on = req.wide ? {req.upper, req.lower} : 2'h1;

  // Parity pins follow their lanes when checking is selected
  always_comb begin
    par_sel = 1'b0;
    unique case (req.space)
      dxs_pkg::DXS_SP_DRAM:
        par_sel = (parity_enable_field == dxs_pkg::DXS_PAR_DRAM);
      dxs_pkg::DXS_SP_EXT:
        par_sel = (parity_enable_field == dxs_pkg::DXS_PAR_AREA2) &&
                  (req.area == dxs_pkg::DXS_PAR_AREA);
      default: par_sel = 1'b0;
    endcase
  end

  assign par_on = par_sel ? lane_on : 2'h0;
  // Odd parity per byte lane
  assign par_bits = {~^req.wdata[15:8], ~^req.wdata[7:0]};

endmodule : dxs_lanes

// ---- dxs_mem_model.sv ----
`timescale 1ns/1ps
// Far-side memory: keeps the row address taken under the row strobe
module dxs_mem_model (
  input wire logic ref_clk,
  input wire dxs_pkg::dxs_pins_t pins,
  output logic [21:0] row_addr
);
  // Latch the row address while the row strobe is low
  always_ff @(posedge ref_clk) begin
    if (!pins.row_strobe_n) begin
      row_addr <= pins.addr;
    end
  end
endmodule : dxs_mem_model

// ---- dxs_strobes_assertions.sv ----
`timescale 1ns/1ps
module dxs_strobes_assertions (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire dxs_pkg::dxs_req_t req,
  input wire logic [1:0] parity_enable_field,
  input wire dxs_pkg::dxs_pins_t pins
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Column phase of a DRAM access, and the external access
  sequence dram_col;
    clk_en && req.space == dxs_pkg::DXS_SP_DRAM && req.col_phase;
  endsequence
  sequence ext_go;
    clk_en && req.space == dxs_pkg::DXS_SP_EXT;
  endsequence
  row_low_a: assert property (
    clk_en && req.space == dxs_pkg::DXS_SP_DRAM && !req.col_phase
    |=> !pins.row_strobe_n) else $error("row strobe not low");
  col_narrow_a: assert property (
    dram_col ##0 !req.wide |=> !pins.lower_col_strobe_n)
    else $error("narrow column strobe missing");
  col_upper_a: assert property (
    dram_col ##0 (req.wide && req.upper && !req.two_we)
    |=> !pins.upper_col_strobe_n) else $error("upper column strobe missing");
  col_lower_a: assert property (
    dram_col ##0 (req.wide && req.lower)
    |=> !pins.lower_col_strobe_n) else $error("lower column strobe missing");
  dram_par_a: assert property (
    dram_col ##0 (req.write && req.wide && req.upper && req.lower
    && parity_enable_field == dxs_pkg::DXS_PAR_DRAM)
    |=> pins.parity_oe == 2'b11) else $error("parity pins idle");
  area_par_a: assert property (
    ext_go ##0 (req.area == 3'h2 && req.write && req.wide && req.lower
    && parity_enable_field == dxs_pkg::DXS_PAR_AREA2)
    |=> pins.lower_parity_pin_o == ~^$past(req.wdata[7:0]))
    else $error("area parity wrong");
  one_sel_a: assert property (
    ext_go |=> pins.area_selects_n == ~(8'h01 << $past(req.area)))
    else $error("chip selects wrong");
  narrow_pin_a: assert property (
    ext_go ##0 !req.wide |=> pins.upper_write_strobe_n)
    else $error("upper write strobe used in narrow space");
  idle_high_a: assert property (
    clk_en && req.space == dxs_pkg::DXS_SP_IDLE |=> pins.row_strobe_n
    && pins.upper_col_strobe_n && pins.lower_col_strobe_n)
    else $error("strobe active while idle");
endmodule : dxs_strobes_assertions

bind dxs_strobes dxs_strobes_assertions chk_i (.ref_clk(ref_clk),
  .resetn(resetn), .clk_en(clk_en), .req(req),
  .parity_enable_field(parity_enable_field), .pins(pins));

// ---- dxs_strobes_tb.sv ----
`timescale 1ns/1ps
module dxs_strobes_tb;
  logic ref_clk;
  logic resetn;
  logic clk_en;
  logic [1:0] parity_enable_field;
  logic [21:0] row_addr;
  logic mode_2we;
  dxs_pkg::dxs_req_t req;
  dxs_pkg::dxs_pins_t pins;
  int mismatches;
  int tests_run;
  dxs_strobes DUT (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
    .req(req), .parity_enable_field(parity_enable_field), .pins(pins));
  dxs_mem_model mem (.ref_clk(ref_clk), .pins(pins), .row_addr(row_addr));
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // One request, then wait until the pins show it
  task put(input dxs_pkg::dxs_space_t s, input logic [3:0] f,
    input logic [2:0] a, input logic c);
    @(posedge ref_clk);
    req <= '{space:s, wide:f[3], upper:f[2], lower:f[1], write:f[0],
      two_we:mode_2we, area:a, col_phase:c, addr:22'h12_3456,
      wdata:16'h5ac3};
    @(posedge ref_clk);
    #1;
  endtask : put
  task t_dram;
    parity_enable_field <= dxs_pkg::DXS_PAR_DRAM;
    put(dxs_pkg::DXS_SP_DRAM, 4'hf, 3'h1, 1'b0);
    chk(pins.row_strobe_n, 1'b0);
    put(dxs_pkg::DXS_SP_DRAM, 4'hf, 3'h1, 1'b1);
    chk(row_addr, 22'h12_3456);
    chk({pins.upper_col_strobe_n, pins.lower_col_strobe_n}, 2'b00);
    chk(pins.parity_oe, 2'b11);
    chk({pins.upper_parity_pin_o, pins.lower_parity_pin_o}, 2'b11);
    put(dxs_pkg::DXS_SP_DRAM, 4'hb, 3'h1, 1'b1);
    chk({pins.upper_col_strobe_n, pins.lower_col_strobe_n}, 2'b10);
    put(dxs_pkg::DXS_SP_DRAM, 4'h1, 3'h1, 1'b1);
    chk({pins.upper_col_strobe_n, pins.lower_col_strobe_n}, 2'b10);
    chk(pins.parity_oe, 2'b01);
    put(dxs_pkg::DXS_SP_IDLE, 4'h0, 3'h0, 1'b0);
    chk({pins.row_strobe_n, pins.area_selects_n}, 9'h1ff);
    $display("t_dram done");
  endtask : t_dram
  task t_ext;
    @(posedge ref_clk);
    parity_enable_field <= dxs_pkg::DXS_PAR_AREA2;
    for (int a = 0; a < 8; a++) begin
      put(dxs_pkg::DXS_SP_EXT, 4'hf, 3'(a), 1'b0);
      chk(pins.area_selects_n, 8'(~(8'h01 << a)));
      chk(pins.parity_oe, (a == 2) ? 2'b11 : 2'b00);
      chk(pins.row_strobe_n, 1'b1);
    end
    put(dxs_pkg::DXS_SP_EXT, 4'h1, 3'h3, 1'b0);
    chk(pins.upper_write_strobe_n, 1'b1);
    $display("t_ext done");
  endtask : t_ext
  // Lane-select and 2-WE systems, a read, and a clock-enable freeze
  task t_mode;
    mode_2we <= 1'b1;
    put(dxs_pkg::DXS_SP_EXT, 4'hb, 3'h2, 1'b0);
    chk({pins.upper_lane_select_n, pins.lower_lane_select_n}, 2'b10);
    chk({pins.lower_write_strobe_n, pins.rd_n}, 2'b01);
    chk(pins.addr, 22'h12_3457);
    chk({pins.data_oe, pins.parity_oe}, 4'h5);
    put(dxs_pkg::DXS_SP_EXT, 4'hc, 3'h2, 1'b0);
    chk({pins.rd_n, pins.data_oe, pins.parity_oe}, 5'h00);
    chk(pins.area_selects_n, 8'hfb);
    clk_en <= 1'b0;
    put(dxs_pkg::DXS_SP_IDLE, 4'h0, 3'h0, 1'b0);
    chk(pins.area_selects_n, 8'hfb);
    clk_en <= 1'b1;
    parity_enable_field <= dxs_pkg::DXS_PAR_DRAM;
    put(dxs_pkg::DXS_SP_DRAM, 4'hd, 3'h1, 1'b1);
    chk({pins.upper_col_strobe_n, pins.lower_col_strobe_n}, 2'b10);
    chk({pins.upper_write_strobe_n, pins.lower_write_strobe_n}, 2'b01);
    chk({pins.area_selects_n[1], pins.parity_oe}, 3'b010);
    mode_2we <= 1'b0;
    $display("t_mode done");
  endtask : t_mode
  task end_sim;
    $display("tests %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  // Watchdog
  initial begin
    #20000;
    mismatches++;
    end_sim();
  end
  initial begin
    resetn = 1'b0;
    clk_en = 1'b1;
    mode_2we = 1'b0;
    parity_enable_field = 2'h0;
    req = '{space:dxs_pkg::DXS_SP_IDLE, default:'0};
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    t_dram();
    t_ext();
    t_mode();
    end_sim();
  end
endmodule : dxs_strobes_tb
